// [switch_spi_regs.svh]
`ifndef SWITCH_SPI_REGS_SVH
`define SWITCH_SPI_REGS_SVH

// ------------------------------------------------------------
// Command word layout
// ------------------------------------------------------------
`define NUM_OUT 2
`define WORD_W 16
`define REG_W 9
`define REG_RST 9'h000
`define CNT_W 4
`define SEL_W 5
`define CMD_WD_BIT 15
`define CMD_GRP_BIT 14
`define CMD_OUT_BIT 13
`define CMD_ADR_MSB 12
`define CMD_ADR_LSB 10
`define ADR_STATUS 3'h0
`define ADR_PWM 3'h1
`define ADR_SWCFG 3'h2
`define ADR_FLTCFG 3'h3
`define ADR_OCCFG 3'h4
`define ADR_GLOBAL 3'h5
`define ADR_CALIB 3'h7
`define SEL_OUT_BIT 3
`define SEL_ADR_MSB 2

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define PWM_LAMP_BIT 8
`define PWM_ON_BIT 7
`define DUTY_MSB 6
`define SW_DIRDIS_BIT 5
`define SLEW_MSB 4
`define SLEW_LSB 3
`define DELAY_MSB 2
`define GCR_VDDEN_BIT 8
`define GCR_PWMEN_BIT 7
`endif

// [switch_spi_pkg.sv]
`include "switch_spi_regs.svh"
package switch_spi_pkg;
   typedef logic [`REG_W-1:0] reg9_t;
   typedef logic [`NUM_OUT-1:0][`REG_W-1:0] reg9_arr_t;
   typedef struct packed {
      logic sclk_s1, sclk_s2, sclk_d;
      logic csn_s1, csn_s2, csn_d;
      logic mosi_s1, mosi_s2;
      logic por_s1, por_s2;
      logic vfail_s1, vfail_s2;
      logic [`NUM_OUT-1:0] din_s1, din_s2;
      logic [`WORD_W-1:0] shift;
      logic [`CNT_W-1:0] cnt;
      logic got;
      logic miso;
      logic miso_oe;
      logic wd;
      logic [`SEL_W-1:0] stsel;
      reg9_arr_t pwm, swcfg, fltcfg, occfg;
      reg9_t global_config, clock_calibration;
      logic [`NUM_OUT-1:0] drive;
      logic [`NUM_OUT-1:0][`DUTY_MSB:0] duty;
      logic [`NUM_OUT-1:0][`DELAY_MSB:0] delay;
   } state_s;
endpackage

// [switch_spi_command_registers.sv]
`timescale 1ns/1ps
`include "switch_spi_regs.svh"
module switch_spi_command_registers
   import switch_spi_pkg::*;
(
   input wire logic clk_i, // Device clock
   input wire logic reset_i, // Sync reset, active high
   input wire logic por_i, // Both supplies below threshold
   input wire logic vdd_fail_i, // Logic supply failure
   input wire logic sclk_i, // Serial clock pin
   input wire logic cs_n_i, // Chip select pin, low active
   input wire logic mosi_i, // Serial data in pin
   input wire logic [`NUM_OUT-1:0] direct_in_i, // Direct input pins
   input wire logic [`WORD_W-1:0] status_word_i, // Device status word
   output logic miso_o, // Serial data out
   output logic miso_oe_o, // Serial out drive enable
   output logic watchdog_toggle_bit_o, // Last received watchdog bit
   output logic [`NUM_OUT-1:0] drive_o, // Output switch request
   output logic [`NUM_OUT-1:0] low_power_lamp_profile_o, // Lamp profile
   output logic [`NUM_OUT-1:0][`DUTY_MSB:0] duty_cycle_field_o, // Duty
   output logic [`NUM_OUT-1:0][`DELAY_MSB:0] switch_delay_field_o, // Delay
   output logic [`NUM_OUT-1:0][`SLEW_MSB-`SLEW_LSB:0] slew_rate_field_o, // Slew
   output reg9_arr_t output_fault_config_o, // Fault config per output
   output reg9_arr_t output_overcurrent_config_o, // Overcurrent config
   output reg9_t global_config_o, // Global config
   output reg9_t clock_calibration_o // Calibration value
);

   state_s q_ff;
   state_s nxt_q;

   logic sclk_rise;
   logic sclk_fall;
   logic cs_fall;
   logic cs_rise;
   logic commit;
   logic wipe;
   logic [`CMD_ADR_MSB-`CMD_ADR_LSB:0] cmd_adr;
   logic cmd_out;
   reg9_t cmd_data;
   logic [`WORD_W-1:0] rb_word;

   // ------------------------------------------------------------
   // Pin edges and command decode
   // ------------------------------------------------------------
   assign sclk_rise = q_ff.sclk_s2 & ~q_ff.sclk_d;
   assign sclk_fall = ~q_ff.sclk_s2 & q_ff.sclk_d;
   assign cs_fall = ~q_ff.csn_s2 & q_ff.csn_d;
   assign cs_rise = q_ff.csn_s2 & ~q_ff.csn_d;
   assign commit = cs_rise & q_ff.got & (q_ff.cnt == '0);
   assign wipe = q_ff.por_s2 | (q_ff.vfail_s2 & q_ff.global_config[`GCR_VDDEN_BIT]);
   assign cmd_adr = q_ff.shift[`CMD_ADR_MSB:`CMD_ADR_LSB];
   assign cmd_out = q_ff.shift[`CMD_OUT_BIT];
   assign cmd_data = q_ff.shift[`REG_W-1:0];

   // ------------------------------------------------------------
   // Readback word, laid out like a command word
   // ------------------------------------------------------------
   always_comb
   begin
      logic osel;
      reg9_t data;
      osel = q_ff.stsel[`SEL_OUT_BIT];
      data = `REG_RST;
      rb_word = '0;
      case (q_ff.stsel[`SEL_ADR_MSB:0])
         `ADR_PWM: data = q_ff.pwm[osel];
         `ADR_SWCFG: data = q_ff.swcfg[osel];
         `ADR_FLTCFG: data = q_ff.fltcfg[osel];
         `ADR_OCCFG: data = q_ff.occfg[osel];
         `ADR_GLOBAL: data = q_ff.global_config;
         `ADR_CALIB: data = q_ff.clock_calibration;
         default: data = `REG_RST;
      endcase
      if (q_ff.stsel[`SEL_ADR_MSB:0] == `ADR_STATUS)
      begin
         rb_word = status_word_i;
      end
      else
      begin
         rb_word[`REG_W-1:0] = data;
         rb_word[`CMD_ADR_MSB:`CMD_ADR_LSB] = q_ff.stsel[`SEL_ADR_MSB:0];
         rb_word[`CMD_OUT_BIT] = osel;
      end
   end

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb
   begin
      nxt_q = q_ff;
      nxt_q.sclk_s1 = sclk_i;
      nxt_q.sclk_s2 = q_ff.sclk_s1;
      nxt_q.sclk_d = q_ff.sclk_s2;
      nxt_q.csn_s1 = cs_n_i;
      nxt_q.csn_s2 = q_ff.csn_s1;
      nxt_q.csn_d = q_ff.csn_s2;
      nxt_q.mosi_s1 = mosi_i;
      nxt_q.mosi_s2 = q_ff.mosi_s1;
      nxt_q.por_s1 = por_i;
      nxt_q.por_s2 = q_ff.por_s1;
      nxt_q.vfail_s1 = vdd_fail_i;
      nxt_q.vfail_s2 = q_ff.vfail_s1;
      nxt_q.din_s1 = direct_in_i;
      nxt_q.din_s2 = q_ff.din_s1;
      nxt_q.miso_oe = ~q_ff.csn_s2;

      // Shift path doubles as daisy chain: bits past the first word pass through
      if (cs_fall)
      begin
         nxt_q.shift = rb_word;
         nxt_q.miso = rb_word[`WORD_W-1];
         nxt_q.cnt = '0;
         nxt_q.got = 1'b0;
      end
      else if (!q_ff.csn_s2)
      begin
         if (sclk_rise)
         begin
            nxt_q.shift = {q_ff.shift[`WORD_W-2:0], q_ff.mosi_s2};
            nxt_q.cnt = q_ff.cnt + 1'b1;
            nxt_q.got = 1'b1;
         end
         if (sclk_fall)
         begin
            nxt_q.miso = q_ff.shift[`WORD_W-1];
         end
      end

      // Only the last sixteen bits of a whole-word frame are latched
      if (commit)
      begin
         nxt_q.wd = q_ff.shift[`CMD_WD_BIT];
         if (cmd_adr == `ADR_STATUS)
         begin
            nxt_q.stsel = q_ff.shift[`SEL_W-1:0];
         end
         else if (q_ff.shift[`CMD_GRP_BIT])
         begin
            case (cmd_adr)
               `ADR_PWM: nxt_q.pwm[cmd_out] = cmd_data;
               `ADR_SWCFG: nxt_q.swcfg[cmd_out] = cmd_data;
               `ADR_FLTCFG: nxt_q.fltcfg[cmd_out] = cmd_data;
               `ADR_OCCFG: nxt_q.occfg[cmd_out] = cmd_data;
               default: nxt_q.stsel = q_ff.stsel;
            endcase
         end
         else if (!cmd_out)
         begin
            case (cmd_adr)
               `ADR_GLOBAL: nxt_q.global_config = cmd_data;
               `ADR_CALIB: nxt_q.clock_calibration = cmd_data;
               default: nxt_q.stsel = q_ff.stsel;
            endcase
         end
      end

      for (int i = 0; i < `NUM_OUT; i++)
      begin
         // PWM module takes over, direct pins are then ignored
         nxt_q.drive[i] = q_ff.pwm[i][`PWM_ON_BIT]
            | (q_ff.din_s2[i] & ~q_ff.swcfg[i][`SW_DIRDIS_BIT]
               & ~q_ff.global_config[`GCR_PWMEN_BIT]);
         nxt_q.duty[i] = q_ff.global_config[`GCR_PWMEN_BIT] ? q_ff.pwm[i][`DUTY_MSB:0] : '0;
         nxt_q.delay[i] = q_ff.global_config[`GCR_PWMEN_BIT] ? q_ff.swcfg[i][`DELAY_MSB:0] : '0;
      end

      if (wipe)
      begin
         nxt_q.stsel = '0;
         nxt_q.wd = 1'b0;
         for (int i = 0; i < `NUM_OUT; i++)
         begin
            nxt_q.pwm[i] = `REG_RST;
            nxt_q.swcfg[i] = `REG_RST;
            nxt_q.fltcfg[i] = `REG_RST;
            nxt_q.occfg[i] = `REG_RST;
         end
         nxt_q.global_config = `REG_RST;
         nxt_q.clock_calibration = `REG_RST;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         q_ff <= '0;
         q_ff.sclk_s1 <= 1'b0;
         q_ff.csn_s1 <= 1'b1;
         q_ff.csn_s2 <= 1'b1;
         q_ff.csn_d <= 1'b1;
      end
      else
      begin
         q_ff <= nxt_q;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign miso_o = q_ff.miso;
   assign miso_oe_o = q_ff.miso_oe;
   assign watchdog_toggle_bit_o = q_ff.wd;
   assign drive_o = q_ff.drive;
   assign duty_cycle_field_o = q_ff.duty;
   assign switch_delay_field_o = q_ff.delay;
   assign output_fault_config_o = q_ff.fltcfg;
   assign output_overcurrent_config_o = q_ff.occfg;
   assign global_config_o = q_ff.global_config;
   assign clock_calibration_o = q_ff.clock_calibration;

   for (genvar g = 0; g < `NUM_OUT; g++)
   begin : g_out
      assign low_power_lamp_profile_o[g] = q_ff.pwm[g][`PWM_LAMP_BIT];
      assign slew_rate_field_o[g] = q_ff.swcfg[g][`SLEW_MSB:`SLEW_LSB];
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (reset_i);

   a_short_frame_drop: assert property (cs_rise && q_ff.cnt != '0 && !wipe |=>
      $stable(q_ff.pwm) && $stable(q_ff.swcfg) && $stable(q_ff.global_config) && $stable(q_ff.stsel))
      else $error("partial frame was latched");

   a_status_sel_only: assert property (commit && cmd_adr == `ADR_STATUS && !wipe |=>
      $stable(q_ff.pwm) && $stable(q_ff.swcfg) && $stable(q_ff.occfg) && $stable(q_ff.global_config)
      && q_ff.stsel == $past(q_ff.shift[`SEL_W-1:0]))
      else $error("status select disturbed registers");

   a_pwm_out_zero: assert property (commit && q_ff.shift[`CMD_GRP_BIT] && cmd_adr == `ADR_PWM
      && !cmd_out && !wipe |=> q_ff.pwm[0] == $past(cmd_data) && $stable(q_ff.pwm[1]))
      else $error("pwm write to output zero wrong");

   a_swcfg_out_one: assert property (commit && q_ff.shift[`CMD_GRP_BIT] && cmd_adr == `ADR_SWCFG
      && cmd_out && !wipe |=> q_ff.swcfg[1] == $past(cmd_data) && $stable(q_ff.swcfg[0]))
      else $error("switching config write to output one wrong");

   a_no_midframe: assert property (!commit && !wipe |=> $stable(q_ff.pwm) && $stable(q_ff.clock_calibration))
      else $error("register changed without commit");

   a_por_clears: assert property (q_ff.por_s2 |=> q_ff.pwm == '0 && q_ff.global_config == '0
      && q_ff.occfg == '0 ##1 low_power_lamp_profile_o == '0)
      else $error("power-on reset did not clear");

   a_vdd_fail_clear: assert property (q_ff.vfail_s2 && q_ff.global_config[`GCR_VDDEN_BIT] |=>
      q_ff.swcfg == '0 && q_ff.fltcfg == '0 && q_ff.clock_calibration == '0)
      else $error("supply failure did not clear");

   a_on_bit_drives: assert property (q_ff.pwm[0][`PWM_ON_BIT] |=> drive_o[0])
      else $error("on bit did not drive output");

   a_direct_ignored: assert property (q_ff.swcfg[1][`SW_DIRDIS_BIT] && !q_ff.pwm[1][`PWM_ON_BIT]
      |=> !drive_o[1])
      else $error("direct input not ignored");

   a_duty_gated: assert property (!q_ff.global_config[`GCR_PWMEN_BIT] |=> duty_cycle_field_o == '0
      && switch_delay_field_o == '0)
      else $error("duty or delay active without pwm enable");

   a_readback_load: assert property (cs_fall |=> miso_o == $past(rb_word[`WORD_W-1])
      ##1 miso_oe_o)
      else $error("readback word not loaded");

   // ------------------------------------------------------------
   // Decode, serial path, readback, output control and supply gating
   // ------------------------------------------------------------

   a_pwm_out_one: assert property (commit && q_ff.shift[`CMD_GRP_BIT] && cmd_adr == `ADR_PWM
      && cmd_out && !wipe |=> q_ff.pwm[1] == $past(cmd_data) && $stable(q_ff.pwm[0]))
      else $error("pwm write to output one wrong");

   a_global_write: assert property (commit && !q_ff.shift[`CMD_GRP_BIT] && !cmd_out
      && cmd_adr == `ADR_GLOBAL && !wipe |=> q_ff.global_config == $past(cmd_data))
      else $error("global config write lost");

   a_calib_write: assert property (commit && !q_ff.shift[`CMD_GRP_BIT] && !cmd_out
      && cmd_adr == `ADR_CALIB && !wipe |=> q_ff.clock_calibration == $past(cmd_data))
      else $error("calibration write lost");

   a_global_guarded: assert property (commit && (q_ff.shift[`CMD_GRP_BIT] || cmd_out)
      && cmd_adr == `ADR_GLOBAL && !wipe |=> $stable(q_ff.global_config) && $stable(q_ff.clock_calibration))
      else $error("global config hit by wrong address");

   a_write_keeps_sel: assert property (commit && cmd_adr != `ADR_STATUS && !wipe |=> $stable(q_ff.stsel))
      else $error("register write moved readback select");

   a_empty_frame_drop: assert property (cs_rise && !q_ff.got && !wipe |=>
      $stable(q_ff.pwm) && $stable(q_ff.swcfg) && $stable(q_ff.stsel))
      else $error("empty frame was latched");

   a_shift_in: assert property (sclk_rise && !q_ff.csn_s2 && !cs_fall |=>
      q_ff.shift[0] == $past(q_ff.mosi_s2) && q_ff.cnt == $past(q_ff.cnt) + 1'b1)
      else $error("serial bit not shifted in");

   a_miso_next: assert property (sclk_fall && !q_ff.csn_s2 && !cs_fall |=>
      miso_o == $past(q_ff.shift[`WORD_W-1]))
      else $error("serial out bit not advanced");

   a_oe_idle: assert property (q_ff.csn_s2 |=> !miso_oe_o)
      else $error("serial out driven while deselected");

   a_status_readback: assert property (cs_fall && q_ff.stsel[`SEL_ADR_MSB:0] == `ADR_STATUS |=>
      q_ff.shift == $past(status_word_i))
      else $error("status word not loaded for readback");

   // Held against the registers themselves, so a bad readback mux is caught
   a_pwm_readback: assert property (cs_fall && q_ff.stsel[`SEL_ADR_MSB:0] == `ADR_PWM && !wipe |=>
      q_ff.shift[`REG_W-1:0] == q_ff.pwm[q_ff.stsel[`SEL_OUT_BIT]])
      else $error("pwm readback wrong");

   a_global_readback: assert property (cs_fall && q_ff.stsel[`SEL_ADR_MSB:0] == `ADR_GLOBAL && !wipe |=>
      q_ff.shift[`REG_W-1:0] == q_ff.global_config && q_ff.shift[`CMD_ADR_MSB:`CMD_ADR_LSB] == `ADR_GLOBAL)
      else $error("global readback wrong");

   a_direct_drives: assert property (q_ff.din_s2[0] && !q_ff.swcfg[0][`SW_DIRDIS_BIT]
      && !q_ff.global_config[`GCR_PWMEN_BIT] |=> drive_o[0])
      else $error("direct input did not drive output");

   a_off_needs_low: assert property (!q_ff.pwm[0][`PWM_ON_BIT] && !q_ff.din_s2[0] |=> !drive_o[0])
      else $error("output on with on bit and direct input low");

   a_duty_enabled: assert property (q_ff.global_config[`GCR_PWMEN_BIT] |=>
      duty_cycle_field_o[0] == $past(q_ff.pwm[0][`DUTY_MSB:0]))
      else $error("duty not passed with pwm enable");

   a_delay_enabled: assert property (q_ff.global_config[`GCR_PWMEN_BIT] |=>
      switch_delay_field_o[1] == $past(q_ff.swcfg[1][`DELAY_MSB:0]))
      else $error("delay not passed with pwm enable");

   a_vdd_fail_gated: assert property (q_ff.vfail_s2 && !q_ff.global_config[`GCR_VDDEN_BIT] && !q_ff.por_s2
      && !commit |=> $stable(q_ff.fltcfg) && $stable(q_ff.occfg))
      else $error("supply failure cleared while detector off");

   c_pwm_write: cover property (commit && cmd_adr == `ADR_PWM && q_ff.shift[`CMD_GRP_BIT]);
   c_short_drop: cover property (cs_rise && q_ff.got && q_ff.cnt != '0);
   c_status_sel: cover property (commit && cmd_adr == `ADR_STATUS ##[1:600] cs_fall);
   c_supply_wipe: cover property (wipe && q_ff.global_config != '0);
   c_pwm_enable: cover property (commit && cmd_adr == `ADR_GLOBAL && cmd_data[`GCR_PWMEN_BIT]);

endmodule

// [spi_host_model.sv]
`timescale 1ns/1ps
module spi_host_model (
   input wire logic clk_i, // Device clock
   input wire logic miso_i, // Serial data from the device
   output logic sclk_o, // Serial clock, still outside frames
   output logic cs_n_o, // Chip select, low active
   output logic mosi_o // Serial data to the device
);
   // ----------------------------------------
   // Frame engine
   // ----------------------------------------
   initial
   begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      mosi_o = 1'b1;
   end
   // Half period of 8 clocks makes the 64 ns link clock
   task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
      rx = '0;
      @(posedge clk_i);
      #1 cs_n_o = 1'b0;
      mosi_o = tx[n-1];
      for (int i = n - 1; i >= 0; i--)
      begin
         repeat (8) @(posedge clk_i);
         rx = {rx[30:0], miso_i};
         #1 sclk_o = 1'b1;
         repeat (8) @(posedge clk_i);
         #1 sclk_o = 1'b0;
         // Released line shows the inverse, never a stale bit
         mosi_o = (i > 0) ? tx[i-1] : ~mosi_o;
      end
      repeat (8) @(posedge clk_i);
      #1 cs_n_o = 1'b1;
      repeat (8) @(posedge clk_i);
   endtask
endmodule

// [switch_spi_command_registers_tb.sv]
`timescale 1ns/1ps
module switch_spi_command_registers_tb;
   import switch_spi_pkg::*;
   logic clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic por_i = 1'b0;
   logic vdd_fail_i = 1'b0;
   logic sclk, cs_n, mosi, miso, wd = 1'b0;
   logic wd_o, oe;
   logic [1:0] direct_in_i = 2'b00;
   logic [15:0] status_word_i = 16'hA5C3;
   logic [1:0] drive_o, lamp_o;
   logic [1:0][6:0] duty_o;
   logic [1:0][2:0] delay_o;
   logic [1:0][1:0] slew_o;
   reg9_arr_t flt_o, oc_o;
   reg9_t gcr_o, cal_o;
   logic [31:0] rx;
   logic [15:0] v;
   int bad_count = 0;
   int compares = 0;
   int cycles = 0;
   // Entries are {output, address, data}
   logic [12:0] tbl [9] = '{13'h0355, 13'h12AA, 13'h040B, 13'h1436, 13'h067F, 13'h1641, 13'h09FF, 13'h1900,
      13'h0EA5};

   always #2 clk_i = ~clk_i;

   switch_spi_command_registers dut_u (.clk_i(clk_i), .reset_i(reset_i), .por_i(por_i),
      .vdd_fail_i(vdd_fail_i), .sclk_i(sclk), .cs_n_i(cs_n), .mosi_i(mosi), .direct_in_i(direct_in_i),
      .status_word_i(status_word_i), .miso_o(miso), .miso_oe_o(oe), .watchdog_toggle_bit_o(wd_o),
      .drive_o(drive_o), .low_power_lamp_profile_o(lamp_o), .duty_cycle_field_o(duty_o),
      .switch_delay_field_o(delay_o), .slew_rate_field_o(slew_o), .output_fault_config_o(flt_o),
      .output_overcurrent_config_o(oc_o), .global_config_o(gcr_o), .clock_calibration_o(cal_o));

   spi_host_model host_u (.clk_i(clk_i), .miso_i(miso), .sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi));

   // ----------------------------------------
   // Access tasks
   // ----------------------------------------
   task automatic chk(input logic [17:0] got, input logic [17:0] exp);
      compares++;
      if (got !== exp)
      begin
         bad_count++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [14:0] w);
      wd = ~wd;
      host_u.xfer({16'h0000, wd, w}, 16, rx);
      chk(18'(wd_o), 18'(wd));
   endtask
   // Readback follows the select in force at the next frame start
   task automatic rd(input logic [4:0] sel, output logic [15:0] r);
      wr({5'b11000, 5'b00000, sel});
      wr({5'b11000, 5'b00000, sel});
      r = rx[15:0];
   endtask
   task automatic setdir(input logic [1:0] d, input logic [1:0] exp);
      @(posedge clk_i) #1 direct_in_i = d;
      repeat (6) @(posedge clk_i);
      chk(18'(drive_o), 18'(exp));
   endtask
   task automatic fail(input logic [1:0] p);
      @(posedge clk_i) #1 {por_i, vdd_fail_i} = p;
      repeat (6) @(posedge clk_i);
      #1 {por_i, vdd_fail_i} = 2'b00;
      repeat (6) @(posedge clk_i);
   endtask
   task automatic give_verdict();
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Whole run is about 16000 cycles
   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles == 60000)
      begin
         bad_count++;
         give_verdict();
      end
   end

   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial
   begin
      repeat (3) @(posedge clk_i);
      #1 reset_i = 1'b0;
      repeat (8) @(posedge clk_i);
      foreach (tbl[i])
      begin
         rd({1'b0, tbl[i][12:9]}, v);
         chk(18'(v), 18'({2'b00, tbl[i][12:9], 10'h000}));
         wr({tbl[i][11:9] != 3'h7, tbl[i][12:9], 1'b0, tbl[i][8:0]});
      end
      foreach (tbl[i])
      begin
         rd({1'b0, tbl[i][12:9]}, v);
         chk(18'(v), 18'({2'b00, tbl[i][12:9], 1'b0, tbl[i][8:0]}));
      end
      $display("test register_readback done");
      chk(18'(lamp_o), 18'h00001);
      chk(18'(slew_o), 18'h00009);
      chk(18'(duty_o), 18'h00000);
      chk(18'(delay_o), 18'h00000);
      chk(18'(oe), 18'h00000);
      chk(18'(flt_o), {9'h041, 9'h07F});
      chk(18'(oc_o), {9'h100, 9'h1FF});
      chk(18'(cal_o), 18'h000A5);
      setdir(2'b01, 2'b11);
      setdir(2'b00, 2'b10);
      wr(15'h642A);
      setdir(2'b10, 2'b00);
      $display("test output_control done");
      rd(5'h00, v);
      chk(18'(v), 18'h0A5C3);
      rd(5'h18, v);
      chk(18'(v), 18'h0A5C3);
      wr(15'h1480);
      chk(18'(duty_o), 18'({7'h2A, 7'h55}));
      chk(18'(delay_o), 18'({3'h6, 3'h3}));
      rd(5'h05, v);
      chk(18'(v), 18'h01480);
      $display("test global_enable done");
      host_u.xfer(32'h00004DAA, 15, rx);
      host_u.xfer(32'h00004DAA, 17, rx);
      chk(18'(flt_o), {9'h041, 9'h07F});
      host_u.xfer(32'h00004DAA, 32, rx);
      chk(18'(flt_o), {9'h041, 9'h1AA});
      $display("test frame_length done");
      fail(2'b01);
      chk(18'(flt_o), {9'h041, 9'h1AA});
      wr(15'h1580);
      fail(2'b01);
      chk(18'({gcr_o, flt_o[0]}), 18'h00000);
      wr(15'h4DAA);
      fail(2'b10);
      chk(18'(flt_o), 18'h00000);
      chk(18'({lamp_o, duty_o}), 18'h00000);
      $display("test supply_wipe done");
      give_verdict();
   end
endmodule
